// ==== design/fgmem_pkg.sv ====
// Constants, command codes and address map of the memory access block
// Assumes a link layer that decodes commands and byte transfers
package fgmem_pkg;

    // ==================================================================
    // Address map
    localparam logic [7:0] ADDR_SPECIAL_FEATURE = 8'h15;
    localparam logic [7:0] ADDR_EEPROM_CONTROL  = 8'h1f;
    localparam logic [7:0] ADDR_USER_FIRST      = 8'h20;
    localparam logic [7:0] ADDR_USER_LAST       = 8'h2f;
    localparam logic [7:0] ADDR_PARAM_FIRST     = 8'h60;
    localparam logic [7:0] ADDR_PARAM_LAST      = 8'h7f;
    localparam int         USER_BYTES           = 16;
    localparam int         PARAM_BYTES          = 32;

    // ==================================================================
    // Field positions
    localparam int BIT_PIN_SENSE   = 0;
    localparam int BIT_COPY_FLAG   = 7;
    localparam int BIT_LOCK_ENABLE = 6;
    localparam int BIT_PARAM_LOCK  = 1;
    localparam int BIT_USER_LOCK   = 0;

    // ==================================================================
    // Reset values and counts
    localparam logic PIN_SENSE_RESET   = 1'b1;
    localparam logic LOCK_ENABLE_RESET = 1'b0;
    localparam int   COPY_CYCLES       = 16;

    // ==================================================================
    // Commands from the link layer
    typedef enum logic [2:0] {
        FGMEM_CMD_READ   = 3'h0,
        FGMEM_CMD_WRITE  = 3'h1,
        FGMEM_CMD_COPY   = 3'h2,
        FGMEM_CMD_RECALL = 3'h3,
        FGMEM_CMD_LOCK   = 3'h4,
        FGMEM_CMD_OTHER  = 3'h5
    } fgmem_cmd_type;

    // Even address of a two-byte register
    function automatic logic is_word_msb(input logic [7:0] addr);
        case (addr)
            8'h02, 8'h04, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12,
            8'h16, 8'h18, 8'h1a, 8'hb0: is_word_msb = 1'b1;
            default:                    is_word_msb = 1'b0;
        endcase
    endfunction

endpackage

// ==== design/fgmem_pin_ctrl.sv ====
// Special feature register: sense and open-drain control of the pin
// Assumes the pin level input is synchronous to ref_clk_in
`timescale 1ns/10ps
module fgmem_pin_ctrl (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // Register access
    input  wire logic wr_en_in,
    input  wire logic wr_bit_in,
    input  wire logic sleep_in,
    // Pin
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe_n_out
);

    logic pin_sense_control_reg;

    // ==================================================================
    // Control bit
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || sleep_in) begin
            pin_sense_control_reg <= fgmem_pkg::PIN_SENSE_RESET;
        end else if (wr_en_in) begin
            pin_sense_control_reg <= wr_bit_in;
        end
    end

    // Driver on while bit is 0
    assign pin_out      = 1'b0;
    assign pin_oe_n_out = pin_sense_control_reg;

    // ==================================================================
    // Checks
    property p_sleep_release;
        @(posedge ref_clk_in) disable iff (rst_in)
        sleep_in |=> pin_oe_n_out;
    endproperty
    a_sleep_release: assert property (p_sleep_release)
        else $error("Pin driven after sleep");

    property p_drive_low;
        @(posedge ref_clk_in) disable iff (rst_in)
        (wr_en_in && !wr_bit_in && !sleep_in) |=>
            !pin_oe_n_out && !pin_out;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("Pin not driven after writing 0");

endmodule

// ==== design/fgmem_eeprom_block.sv ====
// One lockable EEPROM block: shadow RAM over nonvolatile cells
// Assumes the caller decodes addresses into the block's range
`timescale 1ns/10ps
module fgmem_eeprom_block #(
    parameter int BYTES       = 16,
    parameter int COPY_CYCLES = fgmem_pkg::COPY_CYCLES,
    parameter int AW          = $clog2(BYTES)
) (
    // Clock and reset
    input  wire logic          ref_clk_in,
    input  wire logic          rst_in,
    input  wire logic          factory_init_in,
    // Shadow access
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [7:0]    wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [7:0]    rd_data_out,
    // Function commands
    input  wire logic          copy_in,
    input  wire logic          recall_in,
    input  wire logic          lock_in,
    output logic               busy_out,
    output logic               locked_out
);

    localparam int CW = $clog2(COPY_CYCLES + 1);

    logic [7:0]    shadow_mem [BYTES];
    logic [7:0]    cell_mem   [BYTES];
    logic          locked_reg;
    logic [CW-1:0] copy_count_reg;
    logic          wr_ok;

    generate
        if (COPY_CYCLES < 1 || COPY_CYCLES > 999 || BYTES < 2) begin : g_bad
            $error("Unsupported block size or copy time");
        end
    endgenerate

    assign busy_out    = (copy_count_reg != '0);
    assign locked_out  = locked_reg;
    assign rd_data_out = shadow_mem[rd_addr_in];
    assign wr_ok       = wr_en_in && !busy_out && !locked_reg;

    // ==================================================================
    // Shadow RAM, reloaded from cells at reset and on recall
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || (recall_in && !busy_out)) begin
            for (int i = 0; i < BYTES; i++) begin
                shadow_mem[i] <= cell_mem[i];
            end
        end else if (wr_ok) begin
            shadow_mem[wr_addr_in] <= wr_data_in;
        end
    end

    // ==================================================================
    // Cells and lock survive reset
    always_ff @(posedge ref_clk_in) begin
        if (factory_init_in) begin
            for (int i = 0; i < BYTES; i++) begin
                cell_mem[i] <= 8'h00;
            end
        end else if (copy_count_reg == CW'(1)) begin
            for (int i = 0; i < BYTES; i++) begin
                cell_mem[i] <= shadow_mem[i];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (factory_init_in) begin
            locked_reg <= 1'b0;
        end else if (lock_in) begin
            locked_reg <= 1'b1;
        end
    end

    // ==================================================================
    // Copy timer
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            copy_count_reg <= '0;
        end else if (copy_in && !busy_out) begin
            copy_count_reg <= CW'(COPY_CYCLES);
        end else if (busy_out) begin
            copy_count_reg <= copy_count_reg - CW'(1);
        end
    end

    // ==================================================================
    // Checks
    logic [AW-1:0] chk_addr_q;
    logic [7:0]    chk_old_q;
    logic          chk_refused_q;
    always_ff @(posedge ref_clk_in) begin
        chk_addr_q    <= wr_addr_in;
        chk_old_q     <= shadow_mem[wr_addr_in];
        chk_refused_q <= wr_en_in && (busy_out || locked_reg) && !rst_in
                         && !recall_in;
    end

    property p_refused_write;
        @(posedge ref_clk_in) disable iff (rst_in)
        chk_refused_q |-> shadow_mem[chk_addr_q] == chk_old_q;
    endproperty
    a_refused_write: assert property (p_refused_write)
        else $error("Shadow changed by refused write");

    property p_lock_sticks;
        @(posedge ref_clk_in) disable iff (factory_init_in)
        locked_out |=> locked_out;
    endproperty
    a_lock_sticks: assert property (p_lock_sticks)
        else $error("Block lock released");

    // Length of the current busy run
    logic [CW-1:0] chk_busy_len_q;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !busy_out) begin
            chk_busy_len_q <= '0;
        end else begin
            chk_busy_len_q <= chk_busy_len_q + CW'(1);
        end
    end

    sequence s_copy_start;
        copy_in && !busy_out;
    endsequence
    sequence s_copy_end;
        busy_out ##1 !busy_out;
    endsequence
    property p_copy_length;
        @(posedge ref_clk_in) disable iff (rst_in)
        s_copy_start |=> busy_out ##[1:1000] !busy_out;
    endproperty
    a_copy_length: assert property (p_copy_length)
        else $error("Copy busy did not behave");

    property p_copy_cycles;
        @(posedge ref_clk_in) disable iff (rst_in)
        s_copy_end |-> chk_busy_len_q == CW'(COPY_CYCLES);
    endproperty
    a_copy_cycles: assert property (p_copy_cycles)
        else $error("Copy busy length wrong");

endmodule

// ==== design/fgmem_top.sv ====
// Memory map, EEPROM access control and pin control of a fuel gauge
// Assumes a link layer giving command starts and byte accesses
`timescale 1ns/10ps
module fgmem_top #(
    parameter int COPY_CYCLES = fgmem_pkg::COPY_CYCLES
) (
    // Clock and reset
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    factory_init_in,
    // Commands from the link layer
    input  wire logic                    cmd_start_in,
    input  wire fgmem_pkg::fgmem_cmd_type cmd_code_in,
    input  wire logic [7:0]              cmd_addr_in,
    input  wire logic                    cmd_end_in,
    // Byte reads
    input  wire logic                    rd_en_in,
    input  wire logic [7:0]              rd_addr_in,
    output logic      [7:0]              rd_data_out,
    output logic                         rd_valid_out,
    // Byte writes
    input  wire logic                    wr_en_in,
    input  wire logic [7:0]              wr_addr_in,
    input  wire logic [7:0]              wr_data_in,
    // Other registers of the device
    output logic      [7:0]              ext_addr_out,
    input  wire logic [15:0]             ext_word_in,
    output logic                         ext_wr_out,
    output logic      [7:0]              ext_wr_addr_out,
    output logic      [7:0]              ext_wr_data_out,
    // Power mode and pin
    input  wire logic                    sleep_in,
    input  wire logic                    gp_pin_in,
    output logic                         gp_pin_out,
    output logic                         gp_pin_oe_n_out,
    // Status
    output logic                         copy_busy_out
);

    localparam int UAW = $clog2(fgmem_pkg::USER_BYTES);
    localparam int PAW = $clog2(fgmem_pkg::PARAM_BYTES);

    logic       lock_enable_reg;
    logic       latch_valid_reg;
    logic [6:0] latch_addr_reg;
    logic [7:0] latch_lsb_reg;
    logic [7:0] user_rd_data;
    logic [7:0] param_rd_data;
    logic       user_busy;
    logic       param_busy;
    logic       user_locked;
    logic       param_locked;
    logic       wr_user;
    logic       wr_param;
    logic       wr_special;
    logic       rd_user;
    logic       rd_param;
    logic       cmd_user;
    logic       cmd_param;
    logic       do_copy;
    logic       do_recall;
    logic       do_lock;
    logic [7:0] eeprom_reg_value;
    logic [7:0] rd_value;

    // ==================================================================
    // Address decode over the full byte space
    assign rd_user   = rd_addr_in >= fgmem_pkg::ADDR_USER_FIRST &&
                       rd_addr_in <= fgmem_pkg::ADDR_USER_LAST;
    assign rd_param  = rd_addr_in >= fgmem_pkg::ADDR_PARAM_FIRST &&
                       rd_addr_in <= fgmem_pkg::ADDR_PARAM_LAST;
    assign wr_user   = wr_en_in &&
                       wr_addr_in >= fgmem_pkg::ADDR_USER_FIRST &&
                       wr_addr_in <= fgmem_pkg::ADDR_USER_LAST;
    assign wr_param  = wr_en_in &&
                       wr_addr_in >= fgmem_pkg::ADDR_PARAM_FIRST &&
                       wr_addr_in <= fgmem_pkg::ADDR_PARAM_LAST;
    assign wr_special = wr_en_in &&
                       wr_addr_in == fgmem_pkg::ADDR_SPECIAL_FEATURE;
    assign cmd_user  = cmd_addr_in >= fgmem_pkg::ADDR_USER_FIRST &&
                       cmd_addr_in <= fgmem_pkg::ADDR_USER_LAST;
    assign cmd_param = cmd_addr_in >= fgmem_pkg::ADDR_PARAM_FIRST &&
                       cmd_addr_in <= fgmem_pkg::ADDR_PARAM_LAST;

    assign copy_busy_out = user_busy || param_busy;
    assign do_copy   = cmd_start_in && cmd_code_in == fgmem_pkg::FGMEM_CMD_COPY;
    assign do_recall = cmd_start_in &&
                       cmd_code_in == fgmem_pkg::FGMEM_CMD_RECALL &&
                       !copy_busy_out;
    assign do_lock   = cmd_start_in && lock_enable_reg &&
                       cmd_code_in == fgmem_pkg::FGMEM_CMD_LOCK;

    // ==================================================================
    // EEPROM blocks
    fgmem_eeprom_block #(
        .BYTES       (fgmem_pkg::USER_BYTES),
        .COPY_CYCLES (COPY_CYCLES)
    ) u_user_block (
        .ref_clk_in      (ref_clk_in),
        .rst_in          (rst_in),
        .factory_init_in (factory_init_in),
        .wr_en_in        (wr_user && !copy_busy_out),
        .wr_addr_in      (wr_addr_in[UAW-1:0]),
        .wr_data_in      (wr_data_in),
        .rd_addr_in      (rd_addr_in[UAW-1:0]),
        .rd_data_out     (user_rd_data),
        .copy_in         (do_copy && cmd_user && !copy_busy_out),
        .recall_in       (do_recall && cmd_user),
        .lock_in         (do_lock && cmd_user),
        .busy_out        (user_busy),
        .locked_out      (user_locked)
    );

    fgmem_eeprom_block #(
        .BYTES       (fgmem_pkg::PARAM_BYTES),
        .COPY_CYCLES (COPY_CYCLES)
    ) u_param_block (
        .ref_clk_in      (ref_clk_in),
        .rst_in          (rst_in),
        .factory_init_in (factory_init_in),
        .wr_en_in        (wr_param && !copy_busy_out),
        .wr_addr_in      (wr_addr_in[PAW-1:0]),
        .wr_data_in      (wr_data_in),
        .rd_addr_in      (rd_addr_in[PAW-1:0]),
        .rd_data_out     (param_rd_data),
        .copy_in         (do_copy && cmd_param && !copy_busy_out),
        .recall_in       (do_recall && cmd_param),
        .lock_in         (do_lock && cmd_param),
        .busy_out        (param_busy),
        .locked_out      (param_locked)
    );

    // ==================================================================
    // Special feature register
    fgmem_pin_ctrl u_pin_ctrl (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .wr_en_in     (wr_special),
        .wr_bit_in    (wr_data_in[fgmem_pkg::BIT_PIN_SENSE]),
        .sleep_in     (sleep_in),
        .pin_in       (gp_pin_in),
        .pin_out      (gp_pin_out),
        .pin_oe_n_out (gp_pin_oe_n_out)
    );

    // ==================================================================
    // Lock enable: set by write, cleared by the following command
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            lock_enable_reg <= fgmem_pkg::LOCK_ENABLE_RESET;
        end else if (wr_en_in &&
                     wr_addr_in == fgmem_pkg::ADDR_EEPROM_CONTROL &&
                     wr_data_in[fgmem_pkg::BIT_LOCK_ENABLE]) begin
            lock_enable_reg <= 1'b1;
        end else if (cmd_start_in) begin
            lock_enable_reg <= 1'b0;
        end
    end

    always_comb begin
        eeprom_reg_value = 8'h00;
        eeprom_reg_value[fgmem_pkg::BIT_COPY_FLAG]   = copy_busy_out;
        eeprom_reg_value[fgmem_pkg::BIT_LOCK_ENABLE] = lock_enable_reg;
        eeprom_reg_value[fgmem_pkg::BIT_PARAM_LOCK]  = param_locked;
        eeprom_reg_value[fgmem_pkg::BIT_USER_LOCK]   = user_locked;
    end

    // ==================================================================
    // Word latch: MSB read captures the LSB byte for the command
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || cmd_start_in || cmd_end_in) begin
            latch_valid_reg <= 1'b0;
            latch_addr_reg  <= 7'h00;
            latch_lsb_reg   <= 8'h00;
        end else if (rd_en_in && fgmem_pkg::is_word_msb(rd_addr_in)) begin
            latch_valid_reg <= 1'b1;
            latch_addr_reg  <= rd_addr_in[7:1];
            latch_lsb_reg   <= ext_word_in[7:0];
        end
    end

    assign ext_addr_out = {rd_addr_in[7:1], 1'b0};

    // ==================================================================
    // Read data mux
    always_comb begin
        if (rd_addr_in == fgmem_pkg::ADDR_SPECIAL_FEATURE) begin
            rd_value = {7'h00, gp_pin_in};
        end else if (rd_addr_in == fgmem_pkg::ADDR_EEPROM_CONTROL) begin
            rd_value = eeprom_reg_value;
        end else if (rd_user) begin
            rd_value = user_rd_data;
        end else if (rd_param) begin
            rd_value = param_rd_data;
        end else if (!rd_addr_in[0]) begin
            rd_value = ext_word_in[15:8];
        end else if (latch_valid_reg &&
                     latch_addr_reg == rd_addr_in[7:1]) begin
            rd_value = latch_lsb_reg;
        end else begin
            rd_value = ext_word_in[7:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_data_out  <= rd_en_in ? rd_value : rd_data_out;
            rd_valid_out <= rd_en_in;
        end
    end

    // ==================================================================
    // Writes to the rest of the map
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ext_wr_out      <= 1'b0;
            ext_wr_addr_out <= 8'h00;
            ext_wr_data_out <= 8'h00;
        end else begin
            ext_wr_out      <= wr_en_in && !wr_user && !wr_param && !wr_special
                               && wr_addr_in != fgmem_pkg::ADDR_EEPROM_CONTROL;
            ext_wr_addr_out <= wr_en_in ? wr_addr_in : ext_wr_addr_out;
            ext_wr_data_out <= wr_en_in ? wr_data_in : ext_wr_data_out;
        end
    end

    // ==================================================================
    // Checks
    property p_pin_read;
        @(posedge ref_clk_in) disable iff (rst_in)
        (rd_en_in && rd_addr_in == fgmem_pkg::ADDR_SPECIAL_FEATURE) |=>
            rd_data_out == {7'h00, $past(gp_pin_in)};
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("Pin sense read wrong");

    property p_lock_enable_drop;
        @(posedge ref_clk_in) disable iff (rst_in)
        (lock_enable_reg && cmd_start_in && !wr_en_in) |=> !lock_enable_reg;
    endproperty
    a_lock_enable_drop: assert property (p_lock_enable_drop)
        else $error("Lock enable not cleared by next command");

    property p_user_lock;
        @(posedge ref_clk_in) disable iff (rst_in || factory_init_in)
        (do_lock && cmd_user) |=>
            eeprom_reg_value[fgmem_pkg::BIT_USER_LOCK];
    endproperty
    a_user_lock: assert property (p_user_lock)
        else $error("User block lock not reported");

    property p_param_lock;
        @(posedge ref_clk_in) disable iff (rst_in || factory_init_in)
        (do_lock && cmd_param) |=> eeprom_reg_value[1];
    endproperty
    a_param_lock: assert property (p_param_lock)
        else $error("Parameter block lock not reported");

    property p_copy_flag;
        @(posedge ref_clk_in) disable iff (rst_in)
        (do_copy && cmd_user && !copy_busy_out) |=>
            eeprom_reg_value[7] [*2];
    endproperty
    a_copy_flag: assert property (p_copy_flag)
        else $error("Copy flag not set");

    property p_copy_busy_reset;
        @(posedge ref_clk_in)
        rst_in |=> !copy_busy_out;
    endproperty
    a_copy_busy_reset: assert property (p_copy_busy_reset)
        else $error("Copy flag not cleared by reset");

    property p_lock_enable_set;
        @(posedge ref_clk_in) disable iff (rst_in)
        (wr_en_in && wr_addr_in == fgmem_pkg::ADDR_EEPROM_CONTROL &&
         wr_data_in[fgmem_pkg::BIT_LOCK_ENABLE]) |=> lock_enable_reg;
    endproperty
    a_lock_enable_set: assert property (p_lock_enable_set)
        else $error("Lock enable not set by write");

    property p_no_ext_write;
        @(posedge ref_clk_in) disable iff (rst_in)
        (wr_user || wr_param || wr_special) |=> !ext_wr_out;
    endproperty
    a_no_ext_write: assert property (p_no_ext_write)
        else $error("Block write passed to outside registers");

    sequence s_msb_read;
        rd_en_in && fgmem_pkg::is_word_msb(rd_addr_in) && !cmd_start_in
            && !cmd_end_in;
    endsequence
    sequence s_lsb_read(logic [7:0] a);
        rd_en_in && rd_addr_in == a + 8'h01;
    endsequence
    property p_word_latch;
        logic [7:0] a;
        logic [7:0] lsb;
        @(posedge ref_clk_in) disable iff (rst_in)
        (s_msb_read, a = rd_addr_in, lsb = ext_word_in[7:0]) ##1
        ((!cmd_start_in && !cmd_end_in &&
          !(rd_en_in && fgmem_pkg::is_word_msb(rd_addr_in))) throughout
         (##[0:4] s_lsb_read(a))) |=> rd_data_out == lsb;
    endproperty
    a_word_latch: assert property (p_word_latch)
        else $error("LSB changed after MSB read");

endmodule

// ==== test/fgmem_host_model.sv ====
// Host master model: command, byte read and byte write cycles
// Assumes one clock shared with the device, requests off rising edges
`timescale 1ns/10ps
module fgmem_host_model (
    // Clock and read data
    input  wire logic                 clk_in,
    input  wire logic [7:0]           rd_data_in,
    // Commands
    output logic                      start_out,
    output fgmem_pkg::fgmem_cmd_type  code_out,
    output logic      [7:0]           addr_out,
    output logic                      end_out,
    // Byte accesses
    output logic                      rd_en_out,
    output logic      [7:0]           rd_addr_out,
    output logic                      wr_en_out,
    output logic      [7:0]           wr_addr_out,
    output logic      [7:0]           wr_data_out
);
    initial begin
        {start_out, end_out, rd_en_out, wr_en_out} = 4'h0;
        {addr_out, rd_addr_out, wr_addr_out, wr_data_out} = 32'h0;
        code_out = fgmem_pkg::FGMEM_CMD_OTHER;
    end
    // Lock is issued right after the enabling write
    task automatic cmd(input fgmem_pkg::fgmem_cmd_type c,
                       input logic [7:0] a);
        @(posedge clk_in);
        start_out <= 1'b1;
        code_out <= c;
        addr_out <= a;
        @(posedge clk_in);
        start_out <= 1'b0;
    endtask
    // Command ends only after both word bytes are read
    task automatic endc();
        @(posedge clk_in);
        end_out <= 1'b1;
        @(posedge clk_in);
        end_out <= 1'b0;
    endtask
    // Shadow written before copy, recall before verify
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en_out <= 1'b1;
        wr_addr_out <= a;
        wr_data_out <= d;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_en_out <= 1'b1;
        rd_addr_out <= a;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        @(posedge clk_in);
        d = rd_data_in;
    endtask
endmodule

// ==== test/fgmem_top_test.sv ====
// Self-checking bench of the memory access block
// Assumes the host model drives commands and byte accesses
`timescale 1ns/10ps
module fgmem_top_test;
    logic ref_clk_in = 0, rst_in = 1, factory_init_in = 1;
    logic sleep_in = 0, ext_lvl = 1, gp_pin_oe_n_out, copy_busy_out;
    logic gp_pin_out, rd_valid, ext_wr;
    logic [7:0] ext_a, ext_wa, ext_wd;
    logic [15:0] ext_word_in = 16'h0;
    logic start, cend, ren, wen, gp_pin_in;
    logic [7:0] caddr, raddr, waddr, wdata, rdata, d;
    fgmem_pkg::fgmem_cmd_type code;
    int n_mismatch = 0, checked = 0, cyc = 0, n_valid = 0;
    logic [31:0] rows [5] = '{32'h20a520a5, 32'h2f3c2f3c,
        32'h605a605a, 32'h7fc37fc3, 32'h15011f00};
    assign gp_pin_in = gp_pin_oe_n_out ? ext_lvl : 1'b0;
    always #5 ref_clk_in = ~ref_clk_in;
    fgmem_host_model h (.clk_in(ref_clk_in), .rd_data_in(rdata),
        .start_out(start), .code_out(code), .addr_out(caddr),
        .end_out(cend), .rd_en_out(ren), .rd_addr_out(raddr),
        .wr_en_out(wen), .wr_addr_out(waddr), .wr_data_out(wdata));
    fgmem_top #(.COPY_CYCLES(12)) uut (.ref_clk_in, .rst_in,
        .factory_init_in, .cmd_start_in(start), .cmd_code_in(code),
        .cmd_addr_in(caddr), .cmd_end_in(cend), .rd_en_in(ren),
        .rd_addr_in(raddr), .rd_data_out(rdata), .rd_valid_out(rd_valid),
        .wr_en_in(wen), .wr_addr_in(waddr), .wr_data_in(wdata),
        .ext_addr_out(ext_a), .ext_word_in, .ext_wr_out(ext_wr),
        .ext_wr_addr_out(ext_wa), .ext_wr_data_out(ext_wd), .sleep_in,
        .gp_pin_in, .gp_pin_out, .gp_pin_oe_n_out, .copy_busy_out);
    task automatic end_of_test();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        h.rd(a, d);
        chk(d, e);
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (rd_valid === 1'b1) begin
            n_valid++;
        end
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 0;
        factory_init_in <= 0;
        #1 chk({7'h0, gp_pin_oe_n_out}, 8'h01);
        foreach (rows[i]) begin
            h.wr(rows[i][31:24], rows[i][23:16]);
            rc(rows[i][15:8], rows[i][7:0]);
        end
        h.rd(8'h15, d);
        chk(d & 8'h01, 8'h01);
        h.wr(8'h15, 8'h00);
        #1 chk({7'h0, gp_pin_oe_n_out}, 8'h00);
        chk({7'h0, gp_pin_out}, 8'h00);
        h.rd(8'h15, d);
        chk(d & 8'h01, 8'h00);
        sleep_in <= 1;
        repeat (2) @(posedge ref_clk_in);
        #1 chk({7'h0, gp_pin_oe_n_out}, 8'h01);
        @(posedge ref_clk_in);
        sleep_in <= 0;
        ext_lvl <= 0;
        h.rd(8'h15, d);
        chk(d & 8'h01, 8'h00);
        ext_lvl <= 1;
        ext_word_in <= 16'h1234;
        h.cmd(fgmem_pkg::FGMEM_CMD_READ, 8'h00);
        rc(8'h02, 8'h12);
        ext_word_in <= 16'h5678;
        rc(8'h03, 8'h34);
        chk(ext_a, 8'h02);
        h.endc();
        rc(8'h03, 8'h78);
        h.wr(8'h20, 8'h11);
        h.cmd(fgmem_pkg::FGMEM_CMD_COPY, 8'h20);
        #1 chk({7'h0, copy_busy_out}, 8'h01);
        rc(8'h1f, 8'h80);
        h.wr(8'h20, 8'h22);
        for (int i = 0; i < 40 && copy_busy_out !== 1'b0; i++) begin
            @(posedge ref_clk_in);
        end
        rc(8'h20, 8'h11);
        h.wr(8'h20, 8'h33);
        h.cmd(fgmem_pkg::FGMEM_CMD_RECALL, 8'h20);
        rc(8'h20, 8'h11);
        h.wr(8'h1f, 8'h40);
        rc(8'h1f, 8'h40);
        h.cmd(fgmem_pkg::FGMEM_CMD_OTHER, 8'h00);
        rc(8'h1f, 8'h00);
        h.wr(8'h1f, 8'h40);
        h.cmd(fgmem_pkg::FGMEM_CMD_LOCK, 8'h20);
        rc(8'h1f, 8'h01);
        h.wr(8'h20, 8'h99);
        rc(8'h20, 8'h11);
        h.wr(8'h1f, 8'h40);
        h.cmd(fgmem_pkg::FGMEM_CMD_LOCK, 8'h60);
        rc(8'h1f, 8'h03);
        h.wr(8'h01, 8'h5a);
        #1 chk({7'h0, ext_wr}, 8'h01);
        chk(ext_wa, 8'h01);
        chk(ext_wd, 8'h5a);
        @(posedge ref_clk_in);
        chk(8'(n_valid), 8'h13);
        end_of_test();
    end
endmodule
